// [include/brkb_defs.svh]
/*
  Constants of the channel B break condition: register indices, field
  positions, reset values and the host's own command offsets.
  Assumes inclusion by bare name from any file that needs them.
*/
`ifndef BRKB_DEFS_SVH
`define BRKB_DEFS_SVH

// Device register indices on the link
`define BRKB_IDX_ADDR_VAL 4'h0
`define BRKB_IDX_ADDR_MASK 4'h1
`define BRKB_IDX_DATA_VAL 4'h2
`define BRKB_IDX_DATA_MASK 4'h3
`define BRKB_IDX_CYC_SEL 4'h4
`define BRKB_IDX_STATUS 4'h5
`define BRKB_IDX_CLEAR 4'h6
`define BRKB_IDX_ENABLE 4'h7

// Cycle select fields
`define BRKB_CSEL_MBE 9
`define BRKB_CSEL_MBC 8
`define BRKB_CSEL_BUS_LSB 6
`define BRKB_CSEL_ACC_LSB 4
`define BRKB_CSEL_DIR_LSB 2
`define BRKB_CSEL_SIZE_LSB 0
`define BRKB_CSEL_WMASK 16'h03ff

// Reset values
`define BRKB_WORD_RST 32'h0000_0000
`define BRKB_CSEL_RST 16'h0000
`define BRKB_ST_RST 3'h0

// Status bits
`define BRKB_ST_MATCH 0
`define BRKB_ST_LSIDE 1
`define BRKB_ST_IBUS 2

// Bits ignored when a 16-bit memory bus is compared
`define BRKB_X_ADDR_IGN 32'h0001_ffff
`define BRKB_Y_ADDR_IGN 32'hffff_0001
`define BRKB_X_DATA_IGN 32'h0000_ffff
`define BRKB_Y_DATA_IGN 32'hffff_0000

// Host command port window bit and byte offsets
`define BRKB_HOST_WIN_BIT 6
`define BRKB_HOST_CYC_ADDR 8'h40
`define BRKB_HOST_CYC_DATA 8'h44
`define BRKB_HOST_CYC_ATTR 8'h48
`define BRKB_HOST_CYC_GO 8'h4c
`define BRKB_HOST_LAUNCHES 8'h50
`define BRKB_HOST_HITS 8'h54

`endif

// [include/brkb_pkg.sv]
/*
  Types shared by both ends of the channel B break condition link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package brkb_pkg;

  typedef enum logic [1:0]
  {
    BRKB_BUS_L = 2'b00,
    BRKB_BUS_I = 2'b01,
    BRKB_BUS_X = 2'b10,
    BRKB_BUS_Y = 2'b11
  } brkb_bus_type;

  typedef enum logic [1:0]
  {
    BRKB_SZ_ANY = 2'b00,
    BRKB_SZ_BYTE = 2'b01,
    BRKB_SZ_WORD = 2'b10,
    BRKB_SZ_LONG = 2'b11
  } brkb_size_type;

endpackage

// [include/brkb_if.sv]
/*
  Link between the break condition device and the CPU-side end: register
  access and the observed bus cycle, plus the match indication.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface brkb_if;
  import brkb_pkg::*;

  logic [3:0] reg_idx;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic cyc_valid;
  brkb_bus_type cyc_bus;
  logic cyc_fetch;
  logic cyc_write;
  brkb_size_type cyc_size;
  logic [31:0] cyc_addr;
  logic [31:0] cyc_data;
  logic hit;

  modport dev_mp
  (
    input reg_idx, reg_wdata, reg_wr, reg_rd,
    output reg_rdata,
    input cyc_valid, cyc_bus, cyc_fetch, cyc_write, cyc_size, cyc_addr, cyc_data,
    output hit
  );

  modport cpu_mp
  (
    output reg_idx, reg_wdata, reg_wr, reg_rd,
    input reg_rdata,
    output cyc_valid, cyc_bus, cyc_fetch, cyc_write, cyc_size, cyc_addr, cyc_data,
    input hit
  );
endinterface

// [rtl/brkb_masked_cmp.sv]
/*
  Masked equality of one value against a sample; a set mask bit drops
  that bit from the comparison.
  Assumes purely combinational use.
*/
`timescale 1ns/10ps
module brkb_masked_cmp #(
  parameter int WIDTH = 32
)
(
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] mask,
  input wire logic [WIDTH-1:0] sample,
  output logic hit
);

  assign hit = (((value ^ sample) & ~mask) == '0);

endmodule

// [rtl/brkb_cond_dev.sv]
/*
  Channel B break condition device: condition registers, cycle matching,
  sticky event status and a level interrupt.
  Assumes register accesses and bus cycles arrive on REF_CLK through the
  link; register reads are answered in the same cycle as the read strobe.
*/
`timescale 1ns/10ps
`include "brkb_defs.svh"

module brkb_cond_dev
  import brkb_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  brkb_if.dev_mp link,
  output logic MATCH,
  output logic IRQ
);

  logic [31:0] addr_val;
  logic [31:0] addr_mask;
  logic [31:0] data_val;
  logic [31:0] chb_data_mask_reg;
  logic [15:0] chb_cycle_select_reg;
  logic [2:0] status;
  logic [2:0] enable;
  logic [2:0] clear;
  logic [2:0] next_status;
  logic [2:0] events;

  logic memory_bus_enable;
  logic memory_bus_choice;
  logic [1:0] bus_cycle_sel;
  logic [1:0] access_type_sel;
  logic [1:0] direction_sel;
  logic [1:0] size_sel;

  brkb_bus_type want_bus;
  logic bus_ok;
  logic acc_ok;
  logic dir_ok;
  logic size_ok;
  logic data_on;
  logic [31:0] cmp_addr;
  logic [31:0] cmp_addr_mask;
  logic [31:0] cmp_data;
  logic [31:0] cmp_data_mask;
  logic addr_hit;
  logic data_hit;
  logic match_now;

  assign memory_bus_enable = chb_cycle_select_reg[`BRKB_CSEL_MBE];
  assign memory_bus_choice = chb_cycle_select_reg[`BRKB_CSEL_MBC];
  assign bus_cycle_sel = chb_cycle_select_reg[`BRKB_CSEL_BUS_LSB +: 2];
  assign access_type_sel = chb_cycle_select_reg[`BRKB_CSEL_ACC_LSB +: 2];
  assign direction_sel = chb_cycle_select_reg[`BRKB_CSEL_DIR_LSB +: 2];
  assign size_sel = chb_cycle_select_reg[`BRKB_CSEL_SIZE_LSB +: 2];

  // Register writes
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      addr_val <= `BRKB_WORD_RST;
      addr_mask <= `BRKB_WORD_RST;
      data_val <= `BRKB_WORD_RST;
    end
    else if (link.reg_wr)
    begin
      if (link.reg_idx == `BRKB_IDX_ADDR_VAL)
        addr_val <= link.reg_wdata;
      if (link.reg_idx == `BRKB_IDX_ADDR_MASK)
        addr_mask <= link.reg_wdata;
      if (link.reg_idx == `BRKB_IDX_DATA_VAL)
        data_val <= link.reg_wdata;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      chb_data_mask_reg <= `BRKB_WORD_RST;
    else if (link.reg_wr && link.reg_idx == `BRKB_IDX_DATA_MASK)
      chb_data_mask_reg <= link.reg_wdata;
  end

  // Reserved bits never stored, so they always read back as zero
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      chb_cycle_select_reg <= `BRKB_CSEL_RST;
    else if (link.reg_wr && link.reg_idx == `BRKB_IDX_CYC_SEL)
      chb_cycle_select_reg <= link.reg_wdata[15:0] & `BRKB_CSEL_WMASK;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      enable <= `BRKB_ST_RST;
    else if (link.reg_wr && link.reg_idx == `BRKB_IDX_ENABLE)
      enable <= link.reg_wdata[2:0];
  end

  // Read mux, answered combinationally; the far end registers it
  always_comb
  begin
    case (link.reg_idx)
      `BRKB_IDX_ADDR_VAL: link.reg_rdata = addr_val;
      `BRKB_IDX_ADDR_MASK: link.reg_rdata = addr_mask;
      `BRKB_IDX_DATA_VAL: link.reg_rdata = data_val;
      `BRKB_IDX_DATA_MASK: link.reg_rdata = chb_data_mask_reg;
      `BRKB_IDX_CYC_SEL: link.reg_rdata = {16'h0000, chb_cycle_select_reg};
      `BRKB_IDX_STATUS: link.reg_rdata = {29'h0, status};
      `BRKB_IDX_ENABLE: link.reg_rdata = {29'h0, enable};
      default: link.reg_rdata = 32'h0000_0000;
    endcase
  end

  // Bus selection: 01 and 11 both mean the L side
  always_comb
  begin
    if (bus_cycle_sel == 2'b10)
      want_bus = BRKB_BUS_I;
    else if (!memory_bus_enable)
      want_bus = BRKB_BUS_L;
    else if (memory_bus_choice)
      want_bus = BRKB_BUS_Y;
    else
      want_bus = BRKB_BUS_X;
  end

  assign bus_ok = (bus_cycle_sel != 2'b00) && (link.cyc_bus == want_bus);
  assign acc_ok = link.cyc_fetch ? access_type_sel[0] : access_type_sel[1];
  assign dir_ok = link.cyc_write ? direction_sel[1] : direction_sel[0];
  assign size_ok = (size_sel == 2'b00) || (size_sel == link.cyc_size);
  // Data only takes part once a size is chosen
  assign data_on = (size_sel != 2'b00);

  // Memory buses are 16 bits wide; place them in the matching half
  always_comb
  begin
    cmp_addr = link.cyc_addr;
    cmp_addr_mask = addr_mask;
    cmp_data = link.cyc_data;
    cmp_data_mask = chb_data_mask_reg;
    case (link.cyc_bus)
      BRKB_BUS_X:
      begin
        cmp_addr = {link.cyc_addr[15:1], 17'h00000};
        cmp_addr_mask = addr_mask | `BRKB_X_ADDR_IGN;
        cmp_data = {link.cyc_data[15:0], 16'h0000};
        cmp_data_mask = chb_data_mask_reg | `BRKB_X_DATA_IGN;
      end
      BRKB_BUS_Y:
      begin
        cmp_addr = {16'h0000, link.cyc_addr[15:1], 1'b0};
        cmp_addr_mask = addr_mask | `BRKB_Y_ADDR_IGN;
        cmp_data = {16'h0000, link.cyc_data[15:0]};
        cmp_data_mask = chb_data_mask_reg | `BRKB_Y_DATA_IGN;
      end
      default:
      begin
        cmp_addr = link.cyc_addr;
        cmp_addr_mask = addr_mask;
      end
    endcase
  end

  brkb_masked_cmp #(
    .WIDTH(32)
  ) u_addr_cmp (
    .value(addr_val),
    .mask(cmp_addr_mask),
    .sample(cmp_addr),
    .hit(addr_hit)
  );

  brkb_masked_cmp #(
    .WIDTH(32)
  ) u_data_cmp (
    .value(data_val),
    .mask(cmp_data_mask),
    .sample(cmp_data),
    .hit(data_hit)
  );

  assign match_now = link.cyc_valid && bus_ok && acc_ok && dir_ok && size_ok
    && addr_hit && (!data_on || data_hit);

  assign events[`BRKB_ST_MATCH] = match_now;
  assign events[`BRKB_ST_LSIDE] = match_now && (link.cyc_bus != BRKB_BUS_I);
  assign events[`BRKB_ST_IBUS] = match_now && (link.cyc_bus == BRKB_BUS_I);

  assign clear = (link.reg_wr && link.reg_idx == `BRKB_IDX_CLEAR)
    ? link.reg_wdata[2:0] : 3'h0;
  // A new event wins over a clear in the same cycle
  assign next_status = (status & ~clear) | events;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      status <= `BRKB_ST_RST;
    else
      status <= next_status;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      IRQ <= 1'b0;
    else
      IRQ <= |(next_status & enable);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      MATCH <= 1'b0;
      link.hit <= 1'b0;
    end
    else
    begin
      MATCH <= match_now;
      link.hit <= match_now;
    end
  end

endmodule

// [rtl/brkb_cpu_end.sv]
/*
  CPU-side end: forwards software register accesses into the device and
  launches observed bus cycles built from its own command registers.
  Assumes a plain one-cycle strobe master on REF_CLK.
*/
`timescale 1ns/10ps
`include "brkb_defs.svh"

module brkb_cpu_end
  import brkb_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  brkb_if.cpu_mp link
);

  logic win;
  logic [31:0] cyc_addr;
  logic [31:0] cyc_data;
  logic [5:0] cyc_attr;
  logic cyc_valid;
  logic [CNT_W-1:0] launches;
  logic [CNT_W-1:0] hits;
  logic [31:0] own_rdata;

  // Low window maps straight onto the device registers
  assign win = !ADDR[`BRKB_HOST_WIN_BIT];
  assign link.reg_idx = ADDR[5:2];
  assign link.reg_wdata = WDATA;
  assign link.reg_wr = WR && win;
  assign link.reg_rd = RD && win;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      cyc_addr <= `BRKB_WORD_RST;
      cyc_data <= `BRKB_WORD_RST;
      cyc_attr <= 6'h00;
    end
    else if (WR)
    begin
      if (ADDR == `BRKB_HOST_CYC_ADDR)
        cyc_addr <= WDATA;
      if (ADDR == `BRKB_HOST_CYC_DATA)
        cyc_data <= WDATA;
      if (ADDR == `BRKB_HOST_CYC_ATTR)
        cyc_attr <= WDATA[5:0];
    end
  end

  // Byte and word data are presented as software wrote them
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      cyc_valid <= 1'b0;
    else
      cyc_valid <= WR && (ADDR == `BRKB_HOST_CYC_GO);
  end

  assign link.cyc_valid = cyc_valid;
  assign link.cyc_bus = brkb_bus_type'(cyc_attr[1:0]);
  assign link.cyc_fetch = cyc_attr[2];
  assign link.cyc_write = cyc_attr[3];
  assign link.cyc_size = brkb_size_type'(cyc_attr[5:4]);
  assign link.cyc_addr = cyc_addr;
  assign link.cyc_data = cyc_data;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      launches <= '0;
    else if (cyc_valid)
      launches <= launches + 1'b1;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      hits <= '0;
    else if (link.hit)
      hits <= hits + 1'b1;
  end

  always_comb
  begin
    case (ADDR)
      `BRKB_HOST_CYC_ADDR: own_rdata = cyc_addr;
      `BRKB_HOST_CYC_DATA: own_rdata = cyc_data;
      `BRKB_HOST_CYC_ATTR: own_rdata = {26'h0, cyc_attr};
      `BRKB_HOST_LAUNCHES: own_rdata = 32'(launches);
      `BRKB_HOST_HITS: own_rdata = 32'(hits);
      default: own_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      RDATA <= `BRKB_WORD_RST;
    else if (RD)
      RDATA <= win ? link.reg_rdata : own_rdata;
  end

endmodule

// [tb/brkb_properties.sv]
/*
  Concurrent checks on the link between the two break condition ends.
  Assumes one clock and a synchronous active-low reset shared by both ends.
*/
`timescale 1ns/10ps
module brkb_properties
  import brkb_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [3:0] reg_idx,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cyc_valid,
  input wire brkb_bus_type cyc_bus,
  input wire logic cyc_fetch,
  input wire logic cyc_write,
  input wire brkb_size_type cyc_size,
  input wire logic [31:0] cyc_data,
  input wire logic hit
);
  logic [31:0] dmask;
  logic [31:0] dval;
  logic [15:0] csel;

  // Shadows of the written values, so reads and hits are judged from outside
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      dmask <= 32'h0;
      dval <= 32'h0;
      csel <= 16'h0;
    end
    else if (reg_wr)
    begin
      if (reg_idx == 4'h2)
        dval <= reg_wdata;
      if (reg_idx == 4'h3)
        dmask <= reg_wdata;
      if (reg_idx == 4'h4)
        csel <= reg_wdata[15:0];
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  a_mask_readback: assert property (
    reg_idx == 4'h3 |-> reg_rdata == dmask) else $error("data mask read differs");
  a_csel_readback: assert property (
    reg_idx == 4'h4 |-> reg_rdata == {22'h0, csel[9:0]}) else $error("select read differs");
  a_hit_cause: assert property (
    hit |-> $past(cyc_valid)) else $error("hit without a bus cycle");
  a_bus_off: assert property (
    cyc_valid && csel[7:6] == 2'b00 |=> !hit) else $error("hit with compare off");
  a_ibus_only: assert property (
    cyc_valid && csel[7:6] == 2'b10 && cyc_bus != BRKB_BUS_I |=> !hit)
    else $error("hit off the I bus");
  a_xy_choice: assert property (
    cyc_valid && csel[6] && csel[9] && cyc_bus != (csel[8] ? BRKB_BUS_Y : BRKB_BUS_X)
    |=> !hit) else $error("hit on wrong memory bus");
  a_access_sel: assert property (
    cyc_valid && csel[5:4] != 2'b11 && csel[5:4] != (cyc_fetch ? 2'b01 : 2'b10)
    |=> !hit) else $error("hit on wrong access type");
  a_dir_sel: assert property (
    cyc_valid && csel[3:2] != 2'b11 && csel[3:2] != (cyc_write ? 2'b10 : 2'b01)
    |=> !hit) else $error("hit on wrong direction");
  a_size_sel: assert property (
    cyc_valid && csel[1:0] != 2'b00 && cyc_size != csel[1:0] |=> !hit)
    else $error("hit on wrong size");
  a_data_mask: assert property (
    cyc_valid && csel[1:0] != 2'b00 && !csel[9] && ((cyc_data ^ dval) & ~dmask) != 32'h0
    |=> !hit) else $error("hit on unmasked data mismatch");
  a_x_data: assert property (
    cyc_valid && csel[9] && csel[1:0] != 2'b00 && cyc_bus == BRKB_BUS_X
    && ((cyc_data[15:0] ^ dval[31:16]) & ~dmask[31:16]) != 16'h0 |=> !hit)
    else $error("hit on X data mismatch");

  c_hit: cover property (hit);
  c_xy_hit: cover property (hit && csel[9]);
  c_csel_write: cover property (reg_wr && reg_idx == 4'h4);
  c_dev_read: cover property (reg_rd && reg_idx == 4'h3);
endmodule

// [tb/break_channel_b_condition_tb_top.sv]
/*
  Self-checking bench for both ends through the software port.
  Assumes the host map of the CPU-side end and a 20 MHz clock.
*/
`timescale 1ns/10ps
module break_channel_b_condition_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic match;
  logic irq;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int launches = 0;
  int hits_exp = 0;
  logic [15:0] csel_tab [10] = '{16'h003f, 16'h0055, 16'h006a, 16'h00ff, 16'h00bf,
    16'h027f, 16'h037f, 16'h0340, 16'h0073, 16'h007c};
  logic [31:0] dv = 32'h5a5a_5a5a;
  logic [31:0] dm;
  logic [31:0] d;

  brkb_if link_if();
  brkb_cond_dev u_brkb_cond_dev
  (
    .REF_CLK(ref_clk), .RST_N(rst_n), .link(link_if.dev_mp), .MATCH(match), .IRQ(irq)
  );
  brkb_cpu_end u_brkb_cpu_end
  (
    .REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .link(link_if.cpu_mp)
  );
  brkb_properties u_brkb_properties
  (
    .REF_CLK(ref_clk), .RST_N(rst_n), .reg_idx(link_if.reg_idx),
    .reg_wdata(link_if.reg_wdata), .reg_wr(link_if.reg_wr), .reg_rdata(link_if.reg_rdata),
    .reg_rd(link_if.reg_rd),
    .cyc_valid(link_if.cyc_valid), .cyc_bus(link_if.cyc_bus), .cyc_fetch(link_if.cyc_fetch),
    .cyc_write(link_if.cyc_write), .cyc_size(link_if.cyc_size),
    .cyc_data(link_if.cyc_data), .hit(link_if.hit)
  );

  always #25 ref_clk = ~ref_clk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Run length is near 13000 cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe stays up to the next call; idle lowers it
  task automatic wrt(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge ref_clk);
  endtask

  task automatic launch(input logic [5:0] t, input logic [31:0] x, input logic e);
    wrt(8'h48, {26'h0, t});
    wrt(8'h44, x);
    wrt(8'h4c, 32'h0);
    idle(1);
    #1 chk({31'h0, match}, {31'h0, e});
    launches++;
    if (e)
      hits_exp++;
    // Next request starts on a clock edge
    @(posedge ref_clk);
  endtask

  function automatic logic em(logic [15:0] c, logic [5:0] t, logic [31:0] x);
    logic [1:0] b;
    logic ok;
    b = c[9] ? {1'b1, c[8]} : 2'b00;
    ok = c[7:6] == 2'b10 ? t[1:0] == 2'b01 : c[7:6] != 2'b00 && t[1:0] == b;
    ok &= c[5:4] == 2'b11 || c[5:4] == (t[2] ? 2'b01 : 2'b10);
    ok &= c[3:2] == 2'b11 || c[3:2] == (t[3] ? 2'b10 : 2'b01);
    ok &= c[1:0] == 2'b00 || c[1:0] == t[5:4];
    if (c[1:0] != 2'b00)
      ok &= t[1:0] == 2'b10 ? ((x[15:0] ^ dv[31:16]) & ~dm[31:16]) == 16'h0 :
        t[1:0] == 2'b11 ? ((x[15:0] ^ dv[15:0]) & ~dm[15:0]) == 16'h0 :
        ((x ^ dv) & ~dm) == 32'h0;
    return ok;
  endfunction

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(8'h0c, 32'h0);
    rd_chk(8'h10, 32'h0);
    wrt(8'h0c, 32'hffff_ffff);
    wrt(8'h10, 32'hffff_ffff);
    rd_chk(8'h0c, 32'hffff_ffff);
    rd_chk(8'h10, 32'h0000_03ff);
    rd_chk(8'h58, 32'h0);
    $display("test registers finished");
    wrt(8'h04, 32'hffff_ffff);
    wrt(8'h08, dv);
    for (int p = 0; p < 2; p++)
    begin
      dm = p ? 32'h0100_0000 : 32'h0;
      wrt(8'h0c, dm);
      foreach (csel_tab[i])
      begin
        wrt(8'h10, {16'h0, csel_tab[i]});
        for (int t = 0; t < 64; t++)
          for (int k = 0; k < 2; k++)
          begin
            d = k ? dv ^ 32'h0000_0100 : dv;
            launch(t[5:0], d, em(csel_tab[i], t[5:0], d));
          end
      end
    end
    $display("test cycle matching finished");
    // Address now takes part: mask cleared, data left out by size any
    wrt(8'h04, 32'h0);
    wrt(8'h00, 32'h1234_5678);
    wrt(8'h10, 32'h0000_007c);
    wrt(8'h40, 32'h1234_5678);
    launch(6'h00, dv, 1'b1);
    wrt(8'h40, 32'h1234_5679);
    launch(6'h00, dv, 1'b0);
    wrt(8'h10, 32'h0000_037c);
    wrt(8'h40, 32'h0000_5679);
    launch(6'h03, dv, 1'b1);
    $display("test address matching finished");
    idle(2);
    #1 chk({31'h0, irq}, 32'h0);
    @(posedge ref_clk);
    rd_chk(8'h14, 32'h7);
    rd_chk(8'h50, 32'(launches));
    rd_chk(8'h54, 32'(hits_exp));
    wrt(8'h1c, 32'h1);
    idle(2);
    #1 chk({31'h0, irq}, 32'h1);
    @(posedge ref_clk);
    wrt(8'h18, 32'h7);
    idle(2);
    #1 chk({31'h0, irq}, 32'h0);
    @(posedge ref_clk);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h18, 32'h0);
    $display("test interrupt finished");
    complete_run();
  end
endmodule
